// *** design/backup_domain_supply_control.sv ***
// top of the backup domain supply control block: registers, charger key, domain reset
// Summary of operation
// - select field zero: main supply if brownout detector on and clear, else main if backup invalid, backup if main invalid, else higher supply
// - select field nonzero: always backup supply, for debug
// - charging enabled only when the unlock key 3c is written
// - writing the reset field resets the whole backup domain
// - measure enable routes backup supply scaled to 40 percent onto analog bus a
// - thirty-two retained bytes of general-purpose backup storage
// - all registers reachable by firmware over the register port
// - no supply ordering; with select field zero and the brownout detector off or flagged, losing either supply switches to the other
// - domain keeps running in every device power mode
// - alarm request from the clock block is forwarded toward the processor
// - only cold start or the firmware reset field resets the domain
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ns
module backup_domain_supply_control (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic main_valid,
  input wire logic backup_valid,
  input wire logic bod_en,
  input wire logic bod_flag,
  input wire logic main_higher,
  input wire logic alarm_req,
  output logic use_backup,
  output logic charge_en,
  output logic analog_bus_a_meas_en,
  output logic alarm_irq,
  output logic domain_rst
);
  bkp_pkg::bus_req_t req;
  bkp_pkg::supply_in_t sup;
  bkp_pkg::src_t src;
  logic [1:0] sel_q;
  logic [7:0] key_q;
  logic meas_q;
  logic dom_rst_q;
  logic rst;
  logic rd_q;
  logic store_rd_q;
  logic [31:0] reg_rdata_q;
  logic [31:0] store_rdata;
  logic store_hit;
  logic store_we;

  // srst stands for cold start only; device-level resets never reach this port
  // no power-mode input reaches this block, so it behaves alike in every device mode
  assign rst = srst || dom_rst_q;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign sup = '{main_valid: main_valid, backup_valid: backup_valid, bod_en: bod_en,
                 bod_flag: bod_flag, main_higher: main_higher};

  function automatic logic in_store(input logic [7:0] a);
    in_store = a[7:5] == bkp_pkg::OFF_STORE[7:5] && a[1:0] == 2'h0;
  endfunction

  assign store_hit = in_store(req.addr);
  assign store_we = req.wr && store_hit;

  // domain control register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sel_q <= bkp_pkg::SEL_RST;
      key_q <= bkp_pkg::KEY_RST;
      meas_q <= 1'b0;
    end
    else if (req.wr && req.addr == bkp_pkg::OFF_CTRL)
    begin
      sel_q <= req.wdata[bkp_pkg::SEL_POS +: 2];
      key_q <= req.wdata[bkp_pkg::KEY_POS +: 8];
      meas_q <= req.wdata[bkp_pkg::MEAS_POS];
    end
  end

  // domain reset pulse: one cycle, then everything in the domain is back at reset
  always_ff @(posedge clk)
  begin
    if (srst || dom_rst_q)
      dom_rst_q <= 1'b0;
    else
      dom_rst_q <= req.wr && req.addr == bkp_pkg::OFF_RESET && req.wdata[bkp_pkg::RST_POS];
  end

  bkp_switch u_switch (
    .clk(clk),
    .rst(rst),
    .sel(sel_q),
    .sup(sup),
    .src(src)
  );

  bkp_store u_store (
    .clk(clk),
    .clr(rst),
    .we(store_we),
    .waddr(req.addr[4:2]),
    .wdata(req.wdata),
    .raddr(req.addr[4:2]),
    .rdata(store_rdata)
  );

  // outputs, each straight from a flop
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      use_backup <= 1'b0;
      charge_en <= 1'b0;
      analog_bus_a_meas_en <= 1'b0;
      alarm_irq <= 1'b0;
    end
    else
    begin
      use_backup <= src == bkp_pkg::SRC_BACKUP;
      // a battery on the backup pin is the firmware's concern; hardware cannot tell
      charge_en <= key_q == bkp_pkg::CHARGE_KEY;
      analog_bus_a_meas_en <= meas_q;
      alarm_irq <= alarm_req;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      domain_rst <= 1'b0;
    else
      domain_rst <= dom_rst_q;
  end

  // read path: data in the cycle after the strobe only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_q <= 1'b0;
      store_rd_q <= 1'b0;
      reg_rdata_q <= 32'h0000_0000;
    end
    else
    begin
      rd_q <= req.rd;
      store_rd_q <= req.rd && store_hit;
      reg_rdata_q <= 32'h0000_0000;
      if (req.rd)
      begin
        unique case (req.addr)
          bkp_pkg::OFF_CTRL:
            reg_rdata_q <= {16'h0000, key_q, 5'h00, meas_q, sel_q};
          bkp_pkg::OFF_STATUS:
            reg_rdata_q <= {29'h0000_0000, charge_en, analog_bus_a_meas_en, use_backup};
          default:
            reg_rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_comb
  begin
    if (!rd_q)
      rdata = 32'h0000_0000;
    else if (store_rd_q)
      rdata = store_rdata;
    else
      rdata = reg_rdata_q;
  end

  // assertions
  property p_key_charge;
    @(posedge clk) disable iff (srst)
    (wr && addr == bkp_pkg::OFF_CTRL && !dom_rst_q) |=> ##1 (charge_en == (wdata[15:8] == 8'h3c));
  endproperty
  a_key_charge: assert property (p_key_charge) else $error("charge enable not tied to key");

  property p_bad_key;
    @(posedge clk) disable iff (srst)
    (wr && addr == bkp_pkg::OFF_CTRL && wdata[15:8] != 8'h3c) |=> ##1 !charge_en;
  endproperty
  a_bad_key: assert property (p_bad_key) else $error("charging enabled by wrong key");

  property p_debug_sel;
    @(posedge clk) disable iff (srst || dom_rst_q)
    (sel_q != 2'h0) [*3] |-> use_backup;
  endproperty
  a_debug_sel: assert property (p_debug_sel) else $error("debug select did not force backup");

  property p_main_sel;
    @(posedge clk) disable iff (srst || dom_rst_q)
    (sel_q == 2'h0 && bod_en && !bod_flag) ##1 (sel_q == 2'h0) |=> !use_backup;
  endproperty
  a_main_sel: assert property (p_main_sel) else $error("main supply not chosen");

  property p_dom_reset;
    @(posedge clk) disable iff (srst)
    (wr && addr == bkp_pkg::OFF_RESET && wdata[31] && !dom_rst_q) |=> ##1 (sel_q == 2'h0 && key_q == 8'h00 && !meas_q);
  endproperty
  a_dom_reset: assert property (p_dom_reset) else $error("domain reset left state");

  property p_meas;
    @(posedge clk) disable iff (srst || dom_rst_q)
    $changed(meas_q) |=> (analog_bus_a_meas_en == $past(meas_q));
  endproperty
  a_meas: assert property (p_meas) else $error("measure enable not forwarded");

  property p_store;
    @(posedge clk) disable iff (srst || dom_rst_q)
    (wr && in_store(addr)) ##1 (rd && in_store(addr) && addr == $past(addr) && !wr) |=> (rdata == $past(wdata, 2));
  endproperty
  a_store: assert property (p_store) else $error("backup storage lost data");

  property p_no_ctrl_reset;
    @(posedge clk) disable iff (srst)
    (!dom_rst_q && !(wr && addr == bkp_pkg::OFF_CTRL)) |=> $stable(key_q);
  endproperty
  a_no_ctrl_reset: assert property (p_no_ctrl_reset) else $error("control changed without cause");

  property p_alarm;
    @(posedge clk) disable iff (srst || dom_rst_q)
    alarm_req |=> alarm_irq;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not forwarded");

  property p_rd_idle;
    @(posedge clk) disable iff (srst)
    !rd |=> rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside a read");

  property p_rd_reset;
    @(posedge clk) disable iff (srst)
    (rd && addr == bkp_pkg::OFF_RESET) |=> rdata == 32'h0000_0000;
  endproperty
  a_rd_reset: assert property (p_rd_reset) else $error("reset register read not zero");

  property p_rd_unmapped;
    @(posedge clk) disable iff (srst)
    (rd && !in_store(addr) && addr != bkp_pkg::OFF_CTRL && addr != bkp_pkg::OFF_STATUS) |=> rdata == 32'h0000_0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_rd_ctrl;
    @(posedge clk) disable iff (srst)
    (rd && addr == bkp_pkg::OFF_CTRL && !dom_rst_q) |=> rdata == {16'h0000, $past(key_q), 5'h00, $past(meas_q), $past(sel_q)};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  property p_rd_status;
    @(posedge clk) disable iff (srst)
    (rd && addr == bkp_pkg::OFF_STATUS && !dom_rst_q)
      |=> rdata == {29'h0000_0000, $past(charge_en), $past(analog_bus_a_meas_en), $past(use_backup)};
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read wrong");

  property p_store_cleared;
    @(posedge clk) disable iff (srst)
    dom_rst_q ##1 (rd && in_store(addr)) |=> rdata == 32'h0000_0000;
  endproperty
  a_store_cleared: assert property (p_store_cleared) else $error("storage survived domain reset");

  property p_ctrl_write;
    @(posedge clk) disable iff (srst)
    (wr && addr == bkp_pkg::OFF_CTRL && !dom_rst_q)
      |=> (sel_q == $past(wdata[1:0]) && meas_q == $past(wdata[2]) && key_q == $past(wdata[15:8]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not taken");

  property p_charge_src;
    @(posedge clk) disable iff (srst)
    charge_en |-> $past(key_q) == bkp_pkg::CHARGE_KEY;
  endproperty
  a_charge_src: assert property (p_charge_src) else $error("charging without key");

  property p_meas_src;
    @(posedge clk) disable iff (srst)
    analog_bus_a_meas_en |-> $past(meas_q);
  endproperty
  a_meas_src: assert property (p_meas_src) else $error("measure enable without bit");

  property p_alarm_low;
    @(posedge clk) disable iff (srst || dom_rst_q)
    !alarm_req |=> !alarm_irq;
  endproperty
  a_alarm_low: assert property (p_alarm_low) else $error("alarm raised without request");

  property p_no_backup;
    @(posedge clk) disable iff (srst || dom_rst_q)
    (sel_q == 2'h0 && !backup_valid) |=> ##1 !use_backup;
  endproperty
  a_no_backup: assert property (p_no_backup) else $error("switched to missing backup supply");

  property p_no_main;
    @(posedge clk) disable iff (srst || dom_rst_q)
    (sel_q == 2'h0 && backup_valid && !main_valid && !(bod_en && !bod_flag)) |=> ##1 use_backup;
  endproperty
  a_no_main: assert property (p_no_main) else $error("stayed on missing main supply");

  property p_higher;
    @(posedge clk) disable iff (srst || dom_rst_q)
    (sel_q == 2'h0 && backup_valid && main_valid && !(bod_en && !bod_flag))
      |=> ##1 (use_backup == !$past(main_higher, 2));
  endproperty
  a_higher: assert property (p_higher) else $error("higher supply not chosen");

  property p_debug_now;
    @(posedge clk) disable iff (srst || dom_rst_q)
    (sel_q != 2'h0) |=> ##1 use_backup;
  endproperty
  a_debug_now: assert property (p_debug_now) else $error("debug select ignored");

  property p_dom_pulse;
    @(posedge clk) disable iff (srst)
    dom_rst_q |=> !dom_rst_q;
  endproperty
  a_dom_pulse: assert property (p_dom_pulse) else $error("domain reset longer than one cycle");

  property p_dom_out;
    @(posedge clk) disable iff (srst)
    (wr && addr == bkp_pkg::OFF_RESET && wdata[31] && !dom_rst_q) |=> ##1 domain_rst ##1 !domain_rst;
  endproperty
  a_dom_out: assert property (p_dom_out) else $error("domain reset pulse wrong");

  property p_dom_clears;
    @(posedge clk) disable iff (srst)
    dom_rst_q |=> (!use_backup && !charge_en && !analog_bus_a_meas_en && !alarm_irq);
  endproperty
  a_dom_clears: assert property (p_dom_clears) else $error("outputs kept over domain reset");

  property p_cold_start;
    @(posedge clk)
    srst |=> (!use_backup && !charge_en && !analog_bus_a_meas_en && !alarm_irq && !domain_rst
              && sel_q == 2'h0 && key_q == 8'h00 && rdata == 32'h0000_0000);
  endproperty
  a_cold_start: assert property (p_cold_start) else $error("cold start left state");
endmodule

// *** design/bkp_pkg.sv ***
// package: register map, field layout and reset values of the backup domain control block
package bkp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RESET = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_STORE = 8'h40;
  localparam int unsigned STORE_WORDS = 8;
  localparam int unsigned SEL_POS = 0;
  localparam int unsigned MEAS_POS = 2;
  localparam int unsigned KEY_POS = 8;
  localparam int unsigned RST_POS = 31;
  localparam logic [7:0] CHARGE_KEY = 8'h3c;
  localparam logic [1:0] SEL_RST = 2'h0;
  localparam logic [7:0] KEY_RST = 8'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic main_valid;
    logic backup_valid;
    logic bod_en;
    logic bod_flag;
    logic main_higher;
  } supply_in_t;

  typedef enum logic [1:0] {SRC_MAIN, SRC_BACKUP} src_t;
endpackage

// *** design/bkp_store.sv ***
// retained 8x32 backup storage with registered read data
`timescale 1ns/1ns
module bkp_store (
  input wire logic clk,
  input wire logic clr,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [2:0] raddr,
  output logic [31:0] rdata
);
  logic [31:0] mem_q [bkp_pkg::STORE_WORDS];

  // the domain reset clears the retained bytes too
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < bkp_pkg::STORE_WORDS; i++)
    begin
      if (clr)
        mem_q[i] <= bkp_pkg::WORD_RST;
      else if (we && waddr == i[2:0])
        mem_q[i] <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    rdata <= mem_q[raddr];
  end
endmodule

// *** design/bkp_switch.sv ***
// supply selector decision for the domain power switch
`timescale 1ns/1ns
module bkp_switch (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] sel,
  input wire bkp_pkg::supply_in_t sup,
  output bkp_pkg::src_t src
);
  bkp_pkg::src_t src_d;

  always_comb
  begin
    if (sel != bkp_pkg::SEL_RST)
      src_d = bkp_pkg::SRC_BACKUP;
    else if (sup.bod_en && !sup.bod_flag)
      src_d = bkp_pkg::SRC_MAIN;
    else if (!sup.backup_valid)
      src_d = bkp_pkg::SRC_MAIN;
    else if (!sup.main_valid)
      src_d = bkp_pkg::SRC_BACKUP;
    else
      src_d = sup.main_higher ? bkp_pkg::SRC_MAIN : bkp_pkg::SRC_BACKUP;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      src <= bkp_pkg::SRC_MAIN;
    else
      src <= src_d;
  end
endmodule

// *** tb/supply_env.sv ***
// power environment model: supply monitor levels and alarm level seen by the backup domain
`timescale 1ns/1ns
module supply_env (
  input wire logic clk,
  input wire logic [5:0] req,
  output logic main_valid = 1'b0,
  output logic backup_valid = 1'b0,
  output logic bod_en = 1'b0,
  output logic bod_flag = 1'b0,
  output logic main_higher = 1'b0,
  output logic alarm_req = 1'b0
);
  // a supercapacitor sits on the backup supply, so firmware may send the charger key
  always @(posedge clk)
  begin
    {alarm_req, main_higher, bod_flag, bod_en, backup_valid, main_valid} <= req;
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the backup domain supply control block
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [5:0] env_q = 6'h00;
  logic [31:0] rdata;
  logic main_valid, backup_valid, bod_en, bod_flag, main_higher, alarm_req;
  logic use_backup, charge_en, meas_en, alarm_irq, domain_rst;
  logic [31:0] mem [8];
  int n_fail = 0;
  int total_checks = 0;

  always #50 clk = ~clk;

  supply_env supply_env_inst (.clk(clk), .req(env_q), .main_valid(main_valid), .backup_valid(backup_valid),
    .bod_en(bod_en), .bod_flag(bod_flag), .main_higher(main_higher), .alarm_req(alarm_req));

  backup_domain_supply_control backup_domain_supply_control_inst (.clk(clk), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .main_valid(main_valid), .backup_valid(backup_valid),
    .bod_en(bod_en), .bod_flag(bod_flag), .main_higher(main_higher), .alarm_req(alarm_req),
    .use_backup(use_backup), .charge_en(charge_en), .analog_bus_a_meas_en(meas_en),
    .alarm_irq(alarm_irq), .domain_rst(domain_rst));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic br(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // env bits: alarm, main higher, brownout flag, detector on, backup valid, main valid
  function automatic logic exp_bk(input logic [1:0] sel, input logic [5:0] e);
    if (sel != 2'h0)
      return 1'b1;
    if (e[2] && !e[3])
      return 1'b0;
    if (!e[1])
      return 1'b0;
    if (!e[0])
      return 1'b1;
    return !e[4];
  endfunction

  task automatic print_verdict;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    logic [1:0] sel;
    logic [7:0] key;
    logic m;
    int n;
    void'($urandom(37));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk({charge_en, meas_en, use_backup, domain_rst}, 32'h0);
    br(bkp_pkg::OFF_CTRL, 32'h0);
    br(8'h80, 32'h0);
    for (int i = 0; i < 40; i++)
    begin
      sel = 2'(i % 4);
      bw(bkp_pkg::OFF_CTRL, {30'h0, sel});
      env_q <= 6'($urandom);
      repeat (4) @(posedge clk);
      #1;
      chk(use_backup, exp_bk(sel, env_q));
      chk(alarm_irq, env_q[5]);
    end
    for (int i = 0; i < 12; i++)
    begin
      // odd keys can never equal the unlock key
      key = (i % 3 == 0) ? bkp_pkg::CHARGE_KEY : (8'($urandom) | 8'h01);
      m = i[0];
      bw(bkp_pkg::OFF_CTRL, {16'h0, key, 5'h0, m, 2'h0});
      @(posedge clk);
      #1;
      chk(charge_en, key == bkp_pkg::CHARGE_KEY);
      chk(meas_en, m);
      br(bkp_pkg::OFF_CTRL, {16'h0, key, 5'h0, m, 2'h0});
      br(bkp_pkg::OFF_STATUS, {29'h0, key == bkp_pkg::CHARGE_KEY, m, exp_bk(2'h0, env_q)});
    end
    for (int i = 0; i < 8; i++)
    begin
      mem[i] = $urandom;
      bw(8'(bkp_pkg::OFF_STORE + 4 * i), mem[i]);
    end
    for (int i = 0; i < 8; i++)
      br(8'(bkp_pkg::OFF_STORE + 4 * i), mem[i]);
    br(bkp_pkg::OFF_RESET, 32'h0);
    bw(bkp_pkg::OFF_RESET, 32'h8000_0000);
    n = 0;
    repeat (4)
    begin
      #1;
      n += int'(domain_rst);
      @(posedge clk);
    end
    chk(n, 1);
    chk({charge_en, meas_en}, 32'h0);
    br(bkp_pkg::OFF_CTRL, 32'h0);
    br(bkp_pkg::OFF_STORE, 32'h0);
    print_verdict();
  end
endmodule
